// >>> design/rmv_top.sv
// per-reference period monitor, validation and redetect timers
`timescale 1ns/1ps
module rmv_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // system clock status and period
  input wire logic SYSCLK_STABLE,
  input wire logic [rmv_pkg::SYSP_W-1:0] SYSCLK_PERIOD_FS,
  // reference inputs
  input wire logic [rmv_pkg::NUM_REFS-1:0] REF_IN,
  // profile parameters, one entry per profile
  input wire logic [7:0][rmv_pkg::PERIOD_W-1:0] PROF_PERIOD,
  input wire logic [7:0][rmv_pkg::TOL_W-1:0] PROF_INNER_TOL,
  input wire logic [7:0][rmv_pkg::TOL_W-1:0] PROF_OUTER_TOL,
  input wire logic [7:0][rmv_pkg::TMO_W-1:0] PROF_VALID_TMO,
  input wire logic [7:0][rmv_pkg::TMO_W-1:0] PROF_REDET_TMO,
  // per-reference assignment and override controls
  input wire logic [rmv_pkg::NUM_REFS-1:0] REF_MANUAL,
  input wire logic [7:0][rmv_pkg::PROF_W-1:0] REF_MAN_SEL,
  input wire logic [rmv_pkg::NUM_REFS-1:0] MON_BYPASS,
  input wire logic [rmv_pkg::NUM_REFS-1:0] MON_OVERRIDE,
  // register write port
  input wire logic REG_WR,
  input wire logic [rmv_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [rmv_pkg::DATA_W-1:0] REG_WDATA,
  // status
  output logic [rmv_pkg::NUM_REFS-1:0] REF_VALID,
  output logic [rmv_pkg::NUM_REFS-1:0] REF_FAULTED,
  output logic [rmv_pkg::NUM_REFS-1:0] REF_MON_FAULT,
  output logic [rmv_pkg::NUM_REFS-1:0] REF_ASSIGNED,
  output logic [7:0][rmv_pkg::PROF_W-1:0] REF_PROFILE,
  output logic [rmv_pkg::NUM_REFS-1:0] REDETECT_REQ
);

  // ==========================================================
  // helpers
  // true when |meas - nom| / nom exceeds 1/tol (no division needed)
  function automatic logic out_of_tol(
    input logic [rmv_pkg::MEAS_W-1:0] meas,
    input logic [rmv_pkg::PERIOD_W-1:0] nom,
    input logic [rmv_pkg::TOL_W-1:0] tol
  );
    logic [rmv_pkg::MEAS_W-1:0] nom_w;
    logic [rmv_pkg::MEAS_W-1:0] dev;
    logic [rmv_pkg::PROD_W-1:0] prod;
    nom_w = rmv_pkg::MEAS_W'(nom);
    dev = (meas > nom_w) ? meas - nom_w : nom_w - meas;
    prod = rmv_pkg::PROD_W'(dev) * rmv_pkg::PROD_W'(tol);
    return prod > rmv_pkg::PROD_W'(nom);
  endfunction

  // lowest-numbered profile whose outer window holds the measurement
  function automatic logic [rmv_pkg::PROF_W:0] pick_profile(
    input logic [rmv_pkg::MEAS_W-1:0] meas,
    input logic [7:0][rmv_pkg::PERIOD_W-1:0] per,
    input logic [7:0][rmv_pkg::TOL_W-1:0] tol
  );
    logic [rmv_pkg::PROF_W:0] res;
    res = '0;
    for (int p = 7; p >= 0; p--) begin
      if (!out_of_tol(meas, per[p], tol[p])) begin
        res = {1'b1, rmv_pkg::PROF_W'(p)};
      end
    end
    return res;
  endfunction

  // ==========================================================
  // millisecond tick from the programmed system clock period
  logic [rmv_pkg::ACC_W-1:0] acc_r;
  logic [rmv_pkg::ACC_W-1:0] acc_nxt;
  logic ms_tick_r;
  logic ms_tick_nxt;

  always_comb begin
    acc_nxt = acc_r + rmv_pkg::ACC_W'(SYSCLK_PERIOD_FS);
    ms_tick_nxt = 1'b0;
    if (acc_nxt >= rmv_pkg::FS_PER_MS) begin
      acc_nxt = acc_nxt - rmv_pkg::FS_PER_MS; // keeps the fraction
      ms_tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      acc_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      ms_tick_r <= ms_tick_nxt;
    end
  end

  // ==========================================================
  // per-reference state
  logic [rmv_pkg::NUM_REFS-1:0] ref_d_r, ref_d_nxt;
  logic [rmv_pkg::NUM_REFS-1:0] seen_r, seen_nxt;
  logic [7:0][rmv_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [rmv_pkg::NUM_REFS-1:0] mon_fault_r, mon_fault_nxt;
  logic [rmv_pkg::NUM_REFS-1:0] faulted_r, faulted_nxt;
  logic [rmv_pkg::NUM_REFS-1:0] valid_r, valid_nxt;
  logic [7:0][rmv_pkg::TMO_W-1:0] vt_r, vt_nxt;
  logic [7:0][rmv_pkg::TMO_W-1:0] rt_r, rt_nxt;
  logic [rmv_pkg::NUM_REFS-1:0] asg_r, asg_nxt;
  logic [7:0][rmv_pkg::PROF_W-1:0] prof_r, prof_nxt;
  logic [rmv_pkg::NUM_REFS-1:0] redet_r, redet_nxt;

  // force-expiry register is write-only and self-clearing: a pulse only
  logic force_hit;
  assign force_hit = REG_WR && (REG_ADDR == rmv_pkg::FORCE_VAL_ADDR);

  always_comb begin
    logic rise;
    logic done;
    logic expire;
    logic [rmv_pkg::MEAS_W-1:0] meas;
    logic [rmv_pkg::PROF_W:0] pk;
    logic [rmv_pkg::PROF_W-1:0] p;
    logic [rmv_pkg::TMO_W-1:0] vto;
    logic [rmv_pkg::TMO_W-1:0] rto;
    rise = 1'b0;
    done = 1'b0;
    expire = 1'b0;
    meas = '0;
    pk = '0;
    p = '0;
    vto = '0;
    rto = '0;
    ref_d_nxt = REF_IN;
    seen_nxt = seen_r;
    cnt_nxt = cnt_r;
    mon_fault_nxt = mon_fault_r;
    valid_nxt = valid_r;
    vt_nxt = vt_r;
    rt_nxt = rt_r;
    asg_nxt = asg_r;
    prof_nxt = prof_r;
    redet_nxt = '0;
    for (int i = 0; i < rmv_pkg::NUM_REFS; i++) begin
      p = prof_r[i];
      done = 1'b0;
      expire = 1'b0;
      meas = '0;
      // period measurement, restarted at every rising edge
      rise = REF_IN[i] & ~ref_d_r[i];
      if (rise) begin
        cnt_nxt[i] = '0;
        seen_nxt[i] = 1'b1;
        done = seen_r[i]; // first edge only opens the window
        meas = rmv_pkg::MEAS_W'(cnt_r[i] + rmv_pkg::CNT_ONE) *
               rmv_pkg::MEAS_W'(SYSCLK_PERIOD_FS);
      end else if (cnt_r[i] == rmv_pkg::CNT_MAX) begin
        // a stuck reference never completes a period: fault it
        mon_fault_nxt[i] = 1'b1;
      end else begin
        cnt_nxt[i] = cnt_r[i] + rmv_pkg::CNT_ONE;
      end
      // decision held between measurements
      if (done) begin
        if (!asg_r[i]) begin
          mon_fault_nxt[i] = 1'b1;
        end else if (mon_fault_r[i]) begin
          if (!out_of_tol(meas, PROF_PERIOD[p], PROF_INNER_TOL[p])) begin
            mon_fault_nxt[i] = 1'b0;
          end
        end else if (out_of_tol(meas, PROF_PERIOD[p],
                                PROF_OUTER_TOL[p])) begin
          mon_fault_nxt[i] = 1'b1;
        end
      end
      if (!SYSCLK_STABLE) begin
        mon_fault_nxt[i] = 1'b1;
      end
      // profile assignment
      if (REF_MANUAL[i]) begin
        asg_nxt[i] = 1'b1;
        prof_nxt[i] = REF_MAN_SEL[i];
      end else if (done && SYSCLK_STABLE && !asg_r[i]) begin
        pk = pick_profile(meas, PROF_PERIOD, PROF_OUTER_TOL);
        if (pk[rmv_pkg::PROF_W]) begin
          asg_nxt[i] = 1'b1;
          prof_nxt[i] = pk[rmv_pkg::PROF_W-1:0];
        end
      end
      // validation timer and valid latch
      vto = PROF_VALID_TMO[p];
      if (faulted_r[i]) begin
        vt_nxt[i] = '0;
        valid_nxt[i] = 1'b0;
      end else begin
        if (vto != rmv_pkg::TMO_OFF && vt_r[i] < vto && ms_tick_r) begin
          vt_nxt[i] = vt_r[i] + rmv_pkg::TMO_ONE;
          expire = (vt_nxt[i] == vto);
        end
        if (expire || (force_hit && REG_WDATA[i])) begin
          valid_nxt[i] = ~faulted_r[i];
        end
      end
      // redetect timer, automatic assignment only
      rto = PROF_REDET_TMO[p];
      if (!REF_MANUAL[i] && asg_r[i] && faulted_r[i] &&
          rto != rmv_pkg::TMO_OFF) begin
        if (ms_tick_r) begin
          rt_nxt[i] = rt_r[i] + rmv_pkg::TMO_ONE;
          if (rt_nxt[i] >= rto) begin
            rt_nxt[i] = '0;
            asg_nxt[i] = 1'b0;
            redet_nxt[i] = 1'b1;
          end
        end
      end else begin
        rt_nxt[i] = '0;
      end
    end
    // override path into the faulted signal
    faulted_nxt = MON_BYPASS & MON_OVERRIDE |
                  ~MON_BYPASS & (MON_OVERRIDE | mon_fault_r);
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ref_d_r <= '0;
      seen_r <= '0;
      cnt_r <= '0;
      mon_fault_r <= rmv_pkg::MON_FAULT_RST;
      faulted_r <= rmv_pkg::FAULTED_RST;
      valid_r <= rmv_pkg::VALID_RST;
      vt_r <= '0;
      rt_r <= '0;
      asg_r <= rmv_pkg::ASSIGNED_RST;
      prof_r <= '0;
      redet_r <= '0;
    end else begin
      ref_d_r <= ref_d_nxt;
      seen_r <= seen_nxt;
      cnt_r <= cnt_nxt;
      mon_fault_r <= mon_fault_nxt;
      faulted_r <= faulted_nxt;
      valid_r <= valid_nxt;
      vt_r <= vt_nxt;
      rt_r <= rt_nxt;
      asg_r <= asg_nxt;
      prof_r <= prof_nxt;
      redet_r <= redet_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign REF_VALID = valid_r;
  assign REF_FAULTED = faulted_r;
  assign REF_MON_FAULT = mon_fault_r;
  assign REF_ASSIGNED = asg_r;
  assign REF_PROFILE = prof_r;
  assign REDETECT_REQ = redet_r;

endmodule

// >>> design/rmv_pkg.sv
// constants shared by the reference monitor and validation logic
package rmv_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_REFS = 8;
  localparam int PROF_W = 3;
  localparam int PERIOD_W = 50;
  localparam int TOL_W = 20;
  localparam int TMO_W = 16;
  localparam int SYSP_W = 32;
  localparam int CNT_W = 28;
  localparam int MEAS_W = CNT_W + SYSP_W;
  localparam int PROD_W = MEAS_W + TOL_W;
  localparam int ACC_W = 41;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] FORCE_VAL_ADDR = 16'h0a0e;

  // ==========================================================
  // timing
  // one millisecond expressed in femtoseconds
  localparam logic [ACC_W-1:0] FS_PER_MS = 41'h0e8d4a51000;
  localparam logic [CNT_W-1:0] CNT_MAX = 28'hfffffff;
  localparam logic [CNT_W-1:0] CNT_ONE = 28'h0000001;
  localparam logic [TMO_W-1:0] TMO_ONE = 16'h0001;
  localparam logic [TMO_W-1:0] TMO_OFF = 16'h0000;

  // ==========================================================
  // reset values
  localparam logic [NUM_REFS-1:0] MON_FAULT_RST = 8'hff;
  localparam logic [NUM_REFS-1:0] FAULTED_RST = 8'hff;
  localparam logic [NUM_REFS-1:0] VALID_RST = 8'h00;
  localparam logic [NUM_REFS-1:0] ASSIGNED_RST = 8'h00;
endpackage

// >>> testbench/rmv_ref_src.sv
// reference clock sources driving the eight reference inputs
`timescale 1ns/1ps
module rmv_ref_src (
  // clock
  input wire logic clk,
  // period in clock cycles per line, zero parks the line low
  input wire logic [7:0][7:0] per,
  // reference lines
  output logic [7:0] ref_o
);
  logic [7:0][7:0] cnt_r = '0;
  // =====================================================
  // period counters
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (per[i] == 8'h00 || cnt_r[i] + 8'h01 >= per[i]) begin
        cnt_r[i] <= 8'h00;
      end else begin
        cnt_r[i] <= cnt_r[i] + 8'h01;
      end
    end
  end
  // parked lines sit at the receiver's pull-down level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ref_o[i] = per[i] != 8'h00 && cnt_r[i] < (per[i] >> 1);
    end
  end
endmodule

// >>> testbench/rmv_monitor.sv
// port checker for the reference monitor and validation block
`timescale 1ns/1ps
module rmv_monitor #(
  parameter int MIN_HOLD = 200
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // inputs
  input wire logic SYSCLK_STABLE,
  input wire logic [7:0] REF_IN,
  input wire logic [7:0] REF_MANUAL,
  input wire logic [7:0] MON_BYPASS,
  input wire logic [7:0] MON_OVERRIDE,
  input wire logic REG_WR,
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  // status
  input wire logic [7:0] REF_VALID,
  input wire logic [7:0] REF_FAULTED,
  input wire logic [7:0] REF_MON_FAULT,
  input wire logic [7:0] REF_ASSIGNED,
  input wire logic [7:0] REDETECT_REQ
);
  // =====================================================
  // clean run length of reference 2, saturating
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  always_comb begin
    hold_nxt = hold_r + {7'h00, hold_r != 8'hff};
    if (REF_FAULTED[2]) begin
      hold_nxt = 8'h00;
    end
  end
  always_ff @(posedge REF_CLK) begin
    hold_r <= RESET ? 8'h00 : hold_nxt;
  end
  // =====================================================
  // properties
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence force_wr;
    REG_WR && REG_ADDR == rmv_pkg::FORCE_VAL_ADDR;
  endsequence
  sequence req_drop;
    (REDETECT_REQ & (REF_ASSIGNED | ~$past(REF_ASSIGNED))) == 8'h00
    ##1 (REDETECT_REQ & $past(REDETECT_REQ)) == 8'h00;
  endsequence
  force_valid_a: assert property (force_wr |=> (REF_VALID &
    $past(REG_WDATA & ~REF_FAULTED)) == $past(REG_WDATA & ~REF_FAULTED))
    else $error("forced valid missing");
  fault_clear_a: assert property ((REF_VALID & $past(REF_FAULTED)) == 0)
    else $error("valid kept while faulted");
  unstable_a: assert property (!SYSCLK_STABLE |=> &REF_MON_FAULT)
    else $error("fault not forced while unstable");
  fault_mix_a: assert property (REF_FAULTED ==
    $past(MON_OVERRIDE | (~MON_BYPASS & REF_MON_FAULT)))
    else $error("faulted combine wrong");
  meas_only_a: assert property ((~REF_MON_FAULT & $past(REF_MON_FAULT) &
    ~(($past(REF_IN) & ~$past(REF_IN, 2)) | ($past(REF_IN, 2) &
    ~$past(REF_IN, 3)))) == 8'h00) else $error("fault cleared off edge");
  valid_wait_a: assert property ($rose(REF_VALID[2]) && !$past(REG_WR)
    |-> hold_r >= 8'(MIN_HOLD)) else $error("valid too early");
  redet_cause_a: assert property ((REDETECT_REQ & ($past(REF_MANUAL) |
    ~$past(REF_FAULTED))) == 8'h00) else $error("bad redetect");
  redet_pulse_a: assert property (|REDETECT_REQ |-> req_drop)
    else $error("redetect pulse wrong");
  manual_asg_a: assert property (REF_MANUAL[0] && $past(REF_MANUAL[0]) &&
    !$past(RESET) |-> REF_ASSIGNED[0]) else $error("manual unassigned");
endmodule
bind rmv_top rmv_monitor i_mon (
  .REF_CLK(REF_CLK), .RESET(RESET), .SYSCLK_STABLE(SYSCLK_STABLE),
  .REF_IN(REF_IN), .REF_MANUAL(REF_MANUAL), .MON_BYPASS(MON_BYPASS),
  .MON_OVERRIDE(MON_OVERRIDE), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REF_VALID(REF_VALID),
  .REF_FAULTED(REF_FAULTED), .REF_MON_FAULT(REF_MON_FAULT),
  .REF_ASSIGNED(REF_ASSIGNED), .REDETECT_REQ(REDETECT_REQ)
);

// >>> testbench/tb.sv
// self-checking bench for the reference monitor and validation block
`timescale 1ns/1ps
module tb;
  // =====================================================
  // stimulus and status
  logic clk = 1'b0, rst = 1'b1, stb = 1'b0, wr = 1'b0, chk = 1'b0;
  logic [31:0] sp = 32'hee6b2800;
  logic [15:0] adr = 16'h0000;
  logic [7:0] wd = 8'h00, man = 8'hff, byp = 8'h00, ovr = 8'h00;
  logic [7:0] ref_in, val, flt, asg, ev, ef, ea;
  logic [7:0][7:0] per;
  logic [7:0][49:0] pp;
  logic [7:0][19:0] it, ot;
  logic [7:0][15:0] vt, rt;
  logic [7:0][2:0] sel, prf;
  // profile expected on reference 6, zero while it is unassigned
  logic [2:0] ep = 3'h6;
  logic [26:0] q[$];
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  rmv_ref_src i_src (.clk(clk), .per(per), .ref_o(ref_in));
  rmv_top i_dut (
    .REF_CLK(clk), .RESET(rst), .SYSCLK_STABLE(stb),
    .SYSCLK_PERIOD_FS(sp), .REF_IN(ref_in), .PROF_PERIOD(pp),
    .PROF_INNER_TOL(it), .PROF_OUTER_TOL(ot), .PROF_VALID_TMO(vt),
    .PROF_REDET_TMO(rt), .REF_MANUAL(man), .REF_MAN_SEL(sel),
    .MON_BYPASS(byp), .MON_OVERRIDE(ovr), .REG_WR(wr),
    .REG_ADDR(adr), .REG_WDATA(wd), .REF_VALID(val),
    .REF_FAULTED(flt), .REF_MON_FAULT(), .REF_ASSIGNED(asg),
    .REF_PROFILE(prf), .REDETECT_REQ()
  );
  // =====================================================
  // checking
  task automatic check_eq(input logic [26:0] seen, input logic [26:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value valid_faulted_assigned_profile exp %h seen %h",
               exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // the note is taken by the watcher one edge after it is queued
  task automatic want(input int n);
    repeat (n) @(posedge clk);
    q.push_back({ev, ef, ea, ep});
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (chk) begin
      check_eq({val, flt, asg, asg[6] ? prf[6] : 3'h0}, q.pop_front());
    end
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // =====================================================
  // scenarios; reference p runs at 4+2p cycles, one ms is 250 cycles
  initial begin
    void'($urandom(16349));
    for (int p = 0; p < 8; p++) begin
      per[p] = 8'(4 + 2 * p);
      pp[p] = 50'(per[p]) * 50'(sp);
      it[p] = p == 7 ? 20'h00032 : 20'h00064;
      ot[p] = p == 7 ? 20'h0000a : 20'h00032;
      vt[p] = p < 4 ? 16'h0002 : 16'h0000;
      rt[p] = 16'h0001;
      sel[p] = 3'(p);
    end
    {ev, ef, ea} = {8'h00, 8'hff, 8'hff};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    want(100);
    stb <= 1'b1;
    ef = 8'h00;
    want(60);
    ev = 8'h0f;
    want(600);
    wreg(rmv_pkg::FORCE_VAL_ADDR ^ (16'h0001 << $urandom_range(15, 0)), 8'hff);
    want(2);
    wreg(rmv_pkg::FORCE_VAL_ADDR, 8'hf0);
    ev = 8'hff;
    want(1);
    ovr <= 8'h02;
    {ev, ef} = {8'hfd, 8'h02};
    want(3);
    ovr <= 8'h00;
    byp <= 8'h04;
    per[2] <= 8'h14;
    ef = 8'h00;
    want(60);
    ev = 8'hff;
    want(600);
    byp <= 8'h00;
    {ev, ef} = {8'hfb, 8'h04};
    want(3);
    per[2] <= 8'h08;
    ef = 8'h00;
    want(60);
    ev = 8'hff;
    want(600);
    per[7] <= 8'h13;
    want(80);
    per[7] <= 8'h1e;
    {ev, ef} = {8'h7f, 8'h80};
    want(80);
    per[7] <= 8'h13;
    want(80);
    per[7] <= 8'h12;
    ef = 8'h00;
    want(80);
    man <= 8'hbf;
    per[6] <= 8'h28;
    {ev, ef, ea, ep} = {8'h3f, 8'h40, 8'hbf, 3'h0};
    want(700);
    // twelve cycles only fits profile 4, so the search must move it
    per[6] <= 8'h0c;
    {ef, ea, ep} = {8'h00, 8'hff, 3'h4};
    want(150);
    stb <= 1'b0;
    {ev, ef} = {8'h00, 8'hff};
    want(5);
    // let the watcher take the last note before the run ends
    @(posedge clk);
    give_verdict();
  end
endmodule
